//--- design/ppc_port_pin_control.sv
`timescale 1ns/1ps
module ppc_port_pin_control
  import ppc_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // register port
  input wire logic [PPC_ADDR_W-1:0] addr_in,
  input wire logic [PPC_DATA_W-1:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [PPC_DATA_W-1:0] rd_data_out,
  // sampling enables, one-cycle pulses
  input wire logic tb_64hz_tick_in,
  input wire logic sysclk_tick_in,
  // port data latches and levels
  input wire logic [PPC_NUM_PINS-1:0] port_data_in,
  output logic [PPC_NUM_PINS-1:0] pin_level_out,
  // pads
  input wire logic [PPC_NUM_PINS-1:0] pad_in,
  output logic [PPC_NUM_PINS-1:0] pad_out,
  output logic [PPC_NUM_PINS-1:0] pad_oe_out,
  output logic [PPC_NUM_PINS-1:0] pull_en_out,
  output logic [PPC_NUM_PINS-1:0] pull_down_out,
  // serial port
  input wire logic serial_data_out_in,
  input wire logic serial_ready_in,
  input wire logic serial_clk_in,
  input wire logic serial_external_clock_select_in,
  output logic serial_data_in_out,
  output logic serial_clk_out,
  // rc oscillator monitor, asynchronous
  input wire logic rc_osc_clk_in,
  // interrupts
  output logic external0_interrupt_out,
  output logic irq_out
);

  // whole state of the block
  typedef struct packed {
    logic [PPC_NUM_PINS-1:0][3:0] ctrl; // pin control registers
    logic [3:0] port01_control; // holds pull polarity
    logic [3:0] irq_status; // sticky events
    logic [3:0] irq_mask; // interrupt mask
    logic [PPC_DATA_W-1:0] rd_data; // read answer
    logic [PPC_NUM_PINS-1:0] sync1; // first synchroniser stage
    logic [PPC_NUM_PINS-1:0] sync2; // second stage, the only one read
    logic osc_sync1; // monitor clock, first stage
    logic osc_sync2; // monitor clock, second stage
    logic ext0_pulse; // external-0 request pulse
    logic serial_din; // pin 3.3 level to serial port
    logic serial_clk; // pin 4.2 level to serial port
  } ppc_state_t;

  ppc_state_t cur_reg; // registered state
  ppc_state_t cur_next; // next state

  logic [PPC_NUM_PINS-1:0] out_mode; // effective direction per pin
  logic [PPC_NUM_PINS-1:0] out_data; // effective output data per pin
  logic [PPC_NUM_PINS-1:0] sample_en; // effective sampling enable per pin
  logic [PPC_NUM_PINS-1:0] change_vec; // detector pulses from pins
  logic [3:0] ctrl_idx; // control register index of a write
  logic pull_pol; // shared pull polarity

  assign pull_pol = cur_reg.port01_control[PPC_BIT_PULL_POL];
  assign ctrl_idx = 4'(addr_in - PPC_CTRL_BASE_OFS);

  // effective pin function from control bits and serial hand-over
  always_comb begin
    for (int i = 0; i < PPC_NUM_PINS; i++) begin
      out_mode[i] = cur_reg.ctrl[i][PPC_BIT_DIR];
      out_data[i] = port_data_in[i];
      // only the lower pins own a sample select; the rest stay on the tick
      if (i < PPC_NUM_F_PINS && cur_reg.ctrl[i][PPC_BIT_ALT]) begin
        sample_en[i] = sysclk_tick_in;
      end else begin
        sample_en[i] = tb_64hz_tick_in;
      end
    end
    // serial data input forces input mode
    if (cur_reg.ctrl[PPC_PIN_SER_IN][PPC_BIT_ALT]) begin
      out_mode[PPC_PIN_SER_IN] = 1'b0;
    end
    // serial data output forces output mode
    if (cur_reg.ctrl[PPC_PIN_SER_OUT][PPC_BIT_ALT]) begin
      out_mode[PPC_PIN_SER_OUT] = 1'b1;
      out_data[PPC_PIN_SER_OUT] = serial_data_out_in;
    end
    // ready output ignores the direction bit
    if (cur_reg.ctrl[PPC_PIN_SER_RDY][PPC_BIT_ALT]) begin
      out_mode[PPC_PIN_SER_RDY] = 1'b1;
      out_data[PPC_PIN_SER_RDY] = serial_ready_in;
    end
    // transfer clock: direction owned by the serial control
    if (cur_reg.ctrl[PPC_PIN_SCLK][PPC_BIT_ALT]) begin
      out_mode[PPC_PIN_SCLK] = ~serial_external_clock_select_in;
      out_data[PPC_PIN_SCLK] = serial_clk_in;
    end
    // oscillator monitor output
    if (cur_reg.ctrl[PPC_PIN_OSC_OUT][PPC_BIT_ALT]) begin
      out_mode[PPC_PIN_OSC_OUT] = 1'b1;
      out_data[PPC_PIN_OSC_OUT] = cur_reg.osc_sync2;
    end
  end

  // one cell per pin
  for (genvar g = 0; g < PPC_NUM_PINS; g++) begin : g_pin
    ppc_pin_cell u_cell (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .out_mode_in(out_mode[g]),
      .drive_sel_in(cur_reg.ctrl[g][PPC_BIT_DRIVE]),
      .pull_pol_in(pull_pol),
      .out_data_in(out_data[g]),
      .irq_en_in(cur_reg.ctrl[g][PPC_BIT_IE]),
      .level_in(cur_reg.sync2[g]),
      .sample_en_in(sample_en[g]),
      .pad_out_out(pad_out[g]),
      .pad_oe_out(pad_oe_out[g]),
      .pull_en_out(pull_en_out[g]),
      .pull_down_out(pull_down_out[g]),
      .change_out(change_vec[g])
    );
  end

  // next state: synchronisers, register writes and reads, events
  always_comb begin
    cur_next = cur_reg;
    // pads and monitor clock come from outside this clock domain
    cur_next.sync1 = pad_in;
    cur_next.sync2 = cur_reg.sync1;
    cur_next.osc_sync1 = rc_osc_clk_in;
    cur_next.osc_sync2 = cur_reg.osc_sync1;
    cur_next.serial_din = cur_reg.ctrl[PPC_PIN_SER_IN][PPC_BIT_ALT] & cur_reg.sync2[PPC_PIN_SER_IN];
    cur_next.serial_clk = cur_reg.ctrl[PPC_PIN_SCLK][PPC_BIT_ALT] & cur_reg.sync2[PPC_PIN_SCLK];
    cur_next.ext0_pulse = |change_vec;
    cur_next.rd_data = '0;
    // register writes
    if (wr_en_in) begin
      if (addr_in >= PPC_CTRL_BASE_OFS && addr_in <= PPC_CTRL_LAST_OFS) begin
        cur_next.ctrl[ctrl_idx] = wr_data_in;
      end else if (addr_in == PPC_PORT01_CONTROL_OFS) begin
        cur_next.port01_control = wr_data_in;
      end else if (addr_in == PPC_IRQ_MASK_OFS) begin
        cur_next.irq_mask = wr_data_in;
      end
    end
    // register reads; control registers answer zero, being write-only
    if (rd_en_in) begin
      if (addr_in == PPC_IRQ_STATUS_OFS) begin
        cur_next.rd_data = cur_reg.irq_status;
        cur_next.irq_status = '0;
      end else if (addr_in == PPC_IRQ_MASK_OFS) begin
        cur_next.rd_data = cur_reg.irq_mask;
      end else if (addr_in == PPC_LEVEL_P2_OFS) begin
        cur_next.rd_data = cur_reg.sync2[3:0];
      end else if (addr_in == PPC_LEVEL_P3_OFS) begin
        cur_next.rd_data = cur_reg.sync2[7:4];
      end else if (addr_in == PPC_LEVEL_P4_OFS) begin
        cur_next.rd_data = cur_reg.sync2[11:8];
      end
    end
    // event set wins over the read clear
    if (cur_reg.ext0_pulse) begin
      cur_next.irq_status[PPC_ST_EXT0] = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cur_reg <= '0;
      cur_reg.ctrl <= {PPC_NUM_PINS{PPC_CTRL_RST}};
      cur_reg.port01_control <= PPC_PORT01_RST;
      cur_reg.irq_status <= PPC_IRQ_RST;
      cur_reg.irq_mask <= PPC_IRQ_RST;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // outputs
  assign rd_data_out = cur_reg.rd_data;
  assign pin_level_out = cur_reg.sync2;
  assign serial_data_in_out = cur_reg.serial_din;
  assign serial_clk_out = cur_reg.serial_clk;
  assign external0_interrupt_out = cur_reg.ext0_pulse;
  assign irq_out = |(cur_reg.irq_status & cur_reg.irq_mask);

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  a_ctrl_read_zero: assert property (rd_en_in && addr_in >= PPC_CTRL_BASE_OFS && addr_in <= PPC_CTRL_LAST_OFS
                                     |=> rd_data_out == 4'h0)
    else $error("write-only control register read back data");
  a_ie_gates_irq: assert property (change_vec[0] |-> $past(cur_reg.ctrl[0][PPC_BIT_IE] && !out_mode[0]))
    else $error("change pulse while disabled or output");
  a_sample_select: assert property (change_vec[0] |->
                                    $past(cur_reg.ctrl[0][PPC_BIT_ALT] ? sysclk_tick_in : tb_64hz_tick_in))
    else $error("sampled on wrong clock");
  a_fixed_tick: assert property (change_vec[PPC_PIN_SER_OUT] || change_vec[PPC_PIN_SER_IN] |-> $past(tb_64hz_tick_in))
    else $error("fixed pin sampled off the 64 Hz tick");
  // select must still stand, else the forwarded level is legally cleared
  a_ser_in_pin: assert property ($past(cur_reg.ctrl[PPC_PIN_SER_IN][PPC_BIT_ALT])
                                 && cur_reg.ctrl[PPC_PIN_SER_IN][PPC_BIT_ALT] |-> !pad_oe_out[PPC_PIN_SER_IN]
                                 ##1 serial_data_in_out == $past(cur_reg.sync2[PPC_PIN_SER_IN]))
    else $error("serial input pin driven or not passed");
  a_ser_out_drive: assert property ($past(cur_reg.ctrl[PPC_PIN_SER_OUT][PPC_BIT_ALT]
                                    && !cur_reg.ctrl[PPC_PIN_SER_OUT][PPC_BIT_DRIVE])
                                    |-> pad_oe_out[PPC_PIN_SER_OUT] && pad_out[PPC_PIN_SER_OUT] == $past(serial_data_out_in))
    else $error("serial data out not on pin");
  a_ser_rdy_drive: assert property ($past(cur_reg.ctrl[PPC_PIN_SER_RDY][PPC_BIT_ALT]
                                    && !cur_reg.ctrl[PPC_PIN_SER_RDY][PPC_BIT_DRIVE])
                                    |-> pad_oe_out[PPC_PIN_SER_RDY] && pad_out[PPC_PIN_SER_RDY] == $past(serial_ready_in))
    else $error("serial ready not on pin");
  a_sclk_dir: assert property ($past(cur_reg.ctrl[PPC_PIN_SCLK][PPC_BIT_ALT] && !cur_reg.ctrl[PPC_PIN_SCLK][PPC_BIT_DRIVE])
                               |-> pad_oe_out[PPC_PIN_SCLK] == $past(!serial_external_clock_select_in))
    else $error("transfer clock pin direction wrong");
  a_sclk_ext_in: assert property ($past(cur_reg.ctrl[PPC_PIN_SCLK][PPC_BIT_ALT] && serial_external_clock_select_in)
                                  |-> !pad_oe_out[PPC_PIN_SCLK])
    else $error("external transfer clock pin driven");
  a_dir_input: assert property ($past(!cur_reg.ctrl[2][PPC_BIT_DIR]) |-> !pad_oe_out[2])
    else $error("input pin driven");
  a_ext0_or: assert property (|change_vec |=> external0_interrupt_out ##1 cur_reg.irq_status[PPC_ST_EXT0])
    else $error("detection not reaching external-0 request");

  c_ext0_event: cover property (external0_interrupt_out);
  c_status_read_clear: cover property (rd_en_in && addr_in == PPC_IRQ_STATUS_OFS && irq_out);
  c_sclk_external: cover property (cur_reg.ctrl[PPC_PIN_SCLK][PPC_BIT_ALT] && serial_external_clock_select_in);
  c_fast_sample_edge: cover property (change_vec[0] && cur_reg.ctrl[0][PPC_BIT_ALT]);

endmodule

//--- design/ppc_pkg.sv
// shared constants of the port pin control block
package ppc_pkg;

  // sizes
  localparam int PPC_NUM_PINS = 12; // port 2, 3 and 4, four pins each
  localparam int PPC_ADDR_W = 8; // register address width
  localparam int PPC_DATA_W = 4; // register data width

  // register offsets
  localparam logic [7:0] PPC_CTRL_BASE_OFS = 8'h10; // port 2 pin 0 control, one per pin upward
  localparam logic [7:0] PPC_CTRL_LAST_OFS = 8'h1b; // port 4 pin 3 control
  localparam logic [7:0] PPC_PORT4_PIN1_CONTROL_OFS = 8'h19; // port4_pin1_control
  localparam logic [7:0] PPC_PORT4_PIN2_CONTROL_OFS = 8'h1a; // port4_pin2_control
  localparam logic [7:0] PPC_PORT01_CONTROL_OFS = 8'h1c; // port01_control, holds pull polarity
  localparam logic [7:0] PPC_IRQ_STATUS_OFS = 8'h20; // sticky events, read clears
  localparam logic [7:0] PPC_IRQ_MASK_OFS = 8'h21; // interrupt mask
  localparam logic [7:0] PPC_LEVEL_P2_OFS = 8'h24; // sampled pin levels, port 2
  localparam logic [7:0] PPC_LEVEL_P3_OFS = 8'h25; // sampled pin levels, port 3
  localparam logic [7:0] PPC_LEVEL_P4_OFS = 8'h26; // sampled pin levels, port 4

  // control register fields
  localparam int PPC_BIT_DRIVE = 0; // pull or high-z in, push-pull or open-drain out
  localparam int PPC_BIT_DIR = 1; // 0 input, 1 output
  localparam int PPC_BIT_ALT = 2; // sample clock select, serial function select or oscillator monitor output select
  localparam int PPC_BIT_IE = 3; // level change interrupt enable
  localparam int PPC_BIT_PULL_POL = 2; // in port01_control: 0 pull-up, 1 pull-down

  // status field
  localparam int PPC_ST_EXT0 = 0; // external-0 level change event

  // reset values
  localparam logic [3:0] PPC_CTRL_RST = 4'h0;
  localparam logic [3:0] PPC_PORT01_RST = 4'h8;
  localparam logic [3:0] PPC_IRQ_RST = 4'h0;

  // pin indices with special roles
  localparam int PPC_NUM_F_PINS = 7; // pins 2.0 to 3.2 own a sample clock select
  localparam int PPC_PIN_SER_IN = 7; // pin 3.3
  localparam int PPC_PIN_SER_OUT = 8; // pin 4.0
  localparam int PPC_PIN_SER_RDY = 9; // pin 4.1
  localparam int PPC_PIN_SCLK = 10; // pin 4.2
  localparam int PPC_PIN_OSC_OUT = 11; // pin 4.3

endpackage

//--- design/ppc_pin_cell.sv
`timescale 1ns/1ps
// one pin: driver control, pull control and level change detector
module ppc_pin_cell
  import ppc_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // effective control
  input wire logic out_mode_in,
  input wire logic drive_sel_in,
  input wire logic pull_pol_in,
  input wire logic out_data_in,
  input wire logic irq_en_in,
  // sampling
  input wire logic level_in,
  input wire logic sample_en_in,
  // pad side
  output logic pad_out_out,
  output logic pad_oe_out,
  output logic pull_en_out,
  output logic pull_down_out,
  // detector pulse
  output logic change_out
);

  // whole state of the cell
  typedef struct packed {
    logic primed; // a first sample has been taken
    logic prev; // previous sample
    logic pad_out;
    logic pad_oe;
    logic pull_en;
    logic pull_down;
    logic change;
  } ppc_cell_t;

  ppc_cell_t cur_reg; // registered state
  ppc_cell_t cur_next; // next state

  // next state
  always_comb begin
    cur_next = cur_reg;
    cur_next.change = 1'b0;
    // first sample only loads, so a high pin after reset is not seen as an edge
    if (sample_en_in) begin
      cur_next.prev = level_in;
      cur_next.primed = 1'b1;
      cur_next.change = cur_reg.primed & (level_in ^ cur_reg.prev) & irq_en_in & ~out_mode_in;
    end
    // open drain only ever drives low
    cur_next.pad_oe = out_mode_in & (~drive_sel_in | ~out_data_in);
    cur_next.pad_out = out_mode_in & ~drive_sel_in & out_data_in;
    cur_next.pull_en = ~out_mode_in & ~drive_sel_in;
    cur_next.pull_down = ~out_mode_in & ~drive_sel_in & pull_pol_in;
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cur_reg <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // outputs straight from flops
  assign pad_out_out = cur_reg.pad_out;
  assign pad_oe_out = cur_reg.pad_oe;
  assign pull_en_out = cur_reg.pull_en;
  assign pull_down_out = cur_reg.pull_down;
  assign change_out = cur_reg.change;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  a_pull_input_sel: assert property (!$past(srst_in) && $past(!out_mode_in && !drive_sel_in)
                                     |-> pull_en_out && !pad_oe_out)
    else $error("pull input not selected");
  a_hiz_input_sel: assert property ($past(!out_mode_in && drive_sel_in) |-> !pull_en_out && !pad_oe_out)
    else $error("high-z input still pulled or driven");
  a_open_drain_high: assert property ($past(out_mode_in && drive_sel_in) |-> !pad_out_out && pad_oe_out == $past(!out_data_in))
    else $error("open drain drove high");
  a_push_pull_drive: assert property ($past(out_mode_in && !drive_sel_in) |-> pad_oe_out && pad_out_out == $past(out_data_in))
    else $error("push-pull not driving data");
  a_pull_polarity: assert property (pull_en_out |-> pull_down_out == $past(pull_pol_in))
    else $error("pull polarity wrong");
  a_edge_detect: assert property (sample_en_in && cur_reg.primed && (level_in != cur_reg.prev) && irq_en_in
                                  && !out_mode_in |=> change_out ##1 !change_out)
    else $error("level change not pulsed once");
  a_no_false_edge: assert property (change_out |-> $past(sample_en_in) && $past(level_in) != $past(cur_reg.prev))
    else $error("change pulse without level change");

endmodule

//--- testbench/ppc_pin_partner.sv
`timescale 1ns/1ps
// far side of the pads: outside drivers, pull resistors and floating wires
module ppc_pin_partner (
  // clock
  input wire logic clk_in,
  // block side of each pad
  input wire logic [11:0] pad_out_in,
  input wire logic [11:0] pad_oe_in,
  input wire logic [11:0] pull_en_in,
  input wire logic [11:0] pull_down_in,
  // outside drivers, commanded by the bench
  input wire logic [11:0] ext_en_in,
  input wire logic [11:0] ext_val_in,
  // resolved wire level
  output logic [11:0] pad_level_out
);
  logic float_reg = 1'b0; // a floating pad wanders, it never holds a value

  // wander pattern for undriven, unpulled pads
  always @(posedge clk_in) begin
    float_reg <= ~float_reg;
  end

  // block drive wins, then outside driver, then pull, else floating
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      if (pad_oe_in[i]) begin
        pad_level_out[i] = pad_out_in[i];
      end else if (ext_en_in[i]) begin
        pad_level_out[i] = ext_val_in[i];
      end else if (pull_en_in[i]) begin
        pad_level_out[i] = ~pull_down_in[i];
      end else begin
        pad_level_out[i] = float_reg;
      end
    end
  end
endmodule

//--- testbench/testbench.sv
`timescale 1ns/1ps
// self-checking bench of the pin control block
module testbench
  import ppc_pkg::*;
;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic rc_osc = 1'b0; // free monitor clock, unrelated phase
  logic [7:0] addr = 8'h00;
  logic [3:0] wr_data = 4'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic tick_64 = 1'b0;
  logic tick_sys = 1'b0;
  logic ser_dout = 1'b0;
  logic ser_rdy = 1'b0;
  logic ser_clk = 1'b0;
  logic ser_ext = 1'b0;
  logic [11:0] port_data = 12'h000;
  logic [11:0] ext_en = 12'h481; // pins 2.0, 3.3, 4.2 driven from outside
  logic [11:0] ext_val = 12'hfff;
  logic [3:0] rd_data;
  logic [11:0] pin_level, pad_level, pad_out, pad_oe, pull_en, pull_down;
  logic ser_din, ser_clk_o, ext0, irq;
  int err_count = 0;
  int n_compared = 0;

  always #2.5 clk_in = ~clk_in;
  always #7 rc_osc = ~rc_osc;

  ppc_port_pin_control dut_u (.clk_in(clk_in), .srst_in(srst_in), .addr_in(addr), .wr_data_in(wr_data),
    .wr_en_in(wr_en), .rd_en_in(rd_en), .rd_data_out(rd_data), .tb_64hz_tick_in(tick_64),
    .sysclk_tick_in(tick_sys), .port_data_in(port_data), .pin_level_out(pin_level), .pad_in(pad_level),
    .pad_out(pad_out), .pad_oe_out(pad_oe), .pull_en_out(pull_en), .pull_down_out(pull_down),
    .serial_data_out_in(ser_dout), .serial_ready_in(ser_rdy), .serial_clk_in(ser_clk),
    .serial_external_clock_select_in(ser_ext), .serial_data_in_out(ser_din), .serial_clk_out(ser_clk_o),
    .rc_osc_clk_in(rc_osc), .external0_interrupt_out(ext0), .irq_out(irq));

  ppc_pin_partner far_u (.clk_in(clk_in), .pad_out_in(pad_out), .pad_oe_in(pad_oe), .pull_en_in(pull_en),
    .pull_down_in(pull_down), .ext_en_in(ext_en), .ext_val_in(ext_val), .pad_level_out(pad_level));

  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle write, returns once the pads have followed
  task automatic wr(input logic [7:0] a, input logic [3:0] d);
    @(posedge clk_in);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk_in);
    wr_en <= 1'b0;
    @(posedge clk_in);
    #1;
  endtask

  // one-cycle read, data looked at in the single cycle it stands
  task automatic rdc(input string what, input logic [7:0] a, input logic [3:0] exp);
    @(posedge clk_in);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk_in);
    rd_en <= 1'b0;
    #1;
    chk(what, 12'(exp), 12'(rd_data));
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // optional pad flip, then one sample tick; watch for the external-0 pulse
  task automatic ev(input int p, input logic hz, input logic sys, input logic exp);
    logic seen;
    seen = 1'b0;
    if (p >= 0) ext_val[p] = ~ext_val[p];
    wait_cyc(4);
    @(posedge clk_in);
    tick_64 <= hz;
    tick_sys <= sys;
    @(posedge clk_in);
    tick_64 <= 1'b0;
    tick_sys <= 1'b0;
    repeat (6) begin
      @(posedge clk_in);
      #1;
      if (ext0 === 1'b1) seen = 1'b1;
    end
    chk("external0 pulse", 12'(exp), 12'(seen));
  endtask

  task automatic t_reset;
    chk("pad_oe", 12'h000, pad_oe);
    chk("pull_en", 12'hfff, pull_en);
    chk("pull_down", 12'h000, pull_down);
    wr(8'h19, 4'h3);
    rdc("control read", 8'h19, 4'h0);
    rdc("unmapped read", 8'h40, 4'h0);
    rdc("port2 level", PPC_LEVEL_P2_OFS, 4'hf);
    chk("pin_level", 12'hdff, pin_level);
    wr(8'h19, 4'h0);
  endtask

  // pin 2.1: direction, push-pull, open drain, high-z, pull polarity
  task automatic t_drive;
    @(posedge clk_in);
    port_data <= 12'h002;
    wr(8'h11, 4'h2);
    chk("pad_oe", 12'h002, pad_oe);
    chk("pad_out", 12'h002, pad_out & 12'h002);
    wr(8'h11, 4'h3);
    chk("open drain oe", 12'h000, pad_oe);
    port_data <= 12'h000;
    wait_cyc(2);
    chk("open drain low", 12'h002, {pad_oe[11:2], ~pad_out[1], pad_oe[0]});
    wr(8'h11, 4'h1);
    chk("high-z pull", 12'hffd, pull_en);
    wr(PPC_PORT01_CONTROL_OFS, 4'h4);
    chk("pull_down", 12'hffd, pull_down);
    wr(PPC_PORT01_CONTROL_OFS, 4'h0);
    wr(8'h11, 4'h0);
  endtask

  task automatic t_serial;
    wr(8'h17, 4'h6);
    chk("serial in oe", 12'h000, pad_oe);
    ext_val[7] = 1'b0;
    wait_cyc(4);
    chk("serial in", 12'h000, 12'(ser_din));
    wr(8'h17, 4'h0);
    ser_dout <= 1'b1;
    ser_rdy <= 1'b1;
    ser_clk <= 1'b1;
    wr(8'h18, 4'h4);
    wr(8'h19, 4'h4);
    wr(8'h1a, 4'h4);
    wr(8'h1b, 4'h4);
    chk("serial oe", 12'hf00, pad_oe);
    chk("serial out", 12'h700, pad_out & 12'h700);
    ser_dout <= 1'b0;
    ser_rdy <= 1'b0;
    ser_clk <= 1'b0;
    ser_ext <= 1'b1;
    ext_val[10] = 1'b0;
    wait_cyc(4);
    chk("serial out low", 12'h000, pad_out & 12'h300);
    chk("ext clock oe", 12'hb00, pad_oe);
    chk("serial clk in", 12'h000, 12'(ser_clk_o));
    wr(8'h18, 4'h0);
    wr(8'h19, 4'h0);
    wr(8'h1a, 4'h0);
    wr(8'h1b, 4'h0);
  endtask

  task automatic t_irq;
    wr(8'h10, 4'h8);
    ev(-1, 1'b1, 1'b0, 1'b0);
    ev(0, 1'b1, 1'b0, 1'b1);
    chk("irq masked", 12'h000, 12'(irq));
    wr(PPC_IRQ_MASK_OFS, 4'h1);
    chk("irq", 12'h001, 12'(irq));
    rdc("status", PPC_IRQ_STATUS_OFS, 4'h1);
    chk("irq cleared", 12'h000, 12'(irq));
    rdc("status clear", PPC_IRQ_STATUS_OFS, 4'h0);
    ev(-1, 1'b1, 1'b0, 1'b0);
    ev(0, 1'b0, 1'b1, 1'b0);
    ev(-1, 1'b1, 1'b0, 1'b1);
    wr(8'h10, 4'hc);
    ev(0, 1'b0, 1'b1, 1'b1);
    wr(8'h10, 4'h0);
    ev(0, 1'b1, 1'b0, 1'b0);
    wr(8'h17, 4'hc);
    ev(7, 1'b0, 1'b1, 1'b0);
    ev(-1, 1'b1, 1'b0, 1'b1);
    wr(8'h17, 4'ha);
    port_data <= 12'h000;
    ev(-1, 1'b1, 1'b0, 1'b0);
  endtask

  task automatic print_verdict;
    if (err_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // watchdog, far beyond the few hundred cycles the run needs
  initial begin
    #100000;
    err_count++;
    print_verdict();
  end

  initial begin
    repeat (6) @(posedge clk_in);
    srst_in <= 1'b0;
    wait_cyc(2);
    t_reset();
    t_drive();
    t_serial();
    t_irq();
    print_verdict();
  end
endmodule
